// ---- sacf_regs.v ----
// Special function register bank 0x13..0x1c: converter, wake, interrupt-pin,
// timer/PWM upper bits, comparator and pad-measure configuration.
// Assumes a single-cycle core register port on mclk_i; timers feed live counts.
//
// Behaviour
// - Ref select 0 internal, 1 external PA0
// - Level bits 11 VDD 10 4V 01 3V 00 2V
// - Sample width 1,2,4,8 converter clocks
// - Resolution 00 8-bit, 01 10-bit, 1x 12-bit
// - Port B analog-only bits cut digital input
// - Port A analog-only bits, reset clear
// - Five-bit trim magnitude, zero to 11mV
// - Trim sign: 0 decrease, 1 increase
// - Per-pin port A wake enables, reset off
// - Irq2 select puts PA5 on interrupt
// - Irq1 select puts PB1/PA3 on interrupt
// - Irq0 select puts PA4 on interrupt
// - Irq0/1 edge: rise, fall, both; 00 reserved
// - Irq2 edge bit: 0 falling, 1 rising
// - Timer1 upper write reload, read live count
// - Timer4 upper write reload, read live count
// - PWM duty upper bits held, read/write
// - Comparator enable bit, reset off
// - Measure on bit, pad select PA/PB
//
// Strobed register access was left to the implementer.
`include "sacf_map.vh"

module sacf_regs (
	input  wire        mclk_i,
	input  wire        nrst_i,
	input  wire [7:0]  addr_i,
	input  wire [7:0]  wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [7:0]  rdata_o,
	input  wire [9:0]  tmr1_count_i,
	input  wire [9:0]  tmr4_count_i,
	output wire        ext_ref_source_sel_o,
	output wire [1:0]  int_ref_level_sel_o,
	output wire        ref_use_int_o,
	output wire [3:0]  int_ref_onehot_o,
	output wire [1:0]  sample_width_sel_o,
	output wire [3:0]  sample_clocks_o,
	output wire [1:0]  conv_resolution_sel_o,
	output wire [3:0]  conv_bits_o,
	output wire [7:1]  portb_analog_only_o,
	output wire [7:1]  portb_din_en_o,
	output wire [4:0]  porta_analog_only_o,
	output wire [4:0]  porta_din_en_o,
	output wire [4:0]  offset_trim_mag_o,
	output wire        offset_trim_sign_o,
	output wire [7:0]  porta_pin_wake_en_o,
	output wire        ext_irq2_pin_sel_o,
	output wire        ext_irq1_pin_sel_o,
	output wire        ext_irq0_pin_sel_o,
	output wire [1:0]  irq1_edge_sel_o,
	output wire [1:0]  irq0_edge_sel_o,
	output wire        irq2_edge_sel_o,
	output wire [1:0]  irq0_trig_o,
	output wire [1:0]  irq1_trig_o,
	output wire [1:0]  irq2_trig_o,
	output wire [1:0]  tmr1_upper_bits_o,
	output reg         tmr1_load_o,
	output wire [1:0]  tmr4_upper_bits_o,
	output reg         tmr4_load_o,
	output wire [1:0]  pwm_ch1_duty_upper_o,
	output wire [1:0]  pwm_ch2_duty_upper_o,
	output wire [1:0]  pwm_ch3_duty_upper_o,
	output wire [1:0]  pwm_ch4_duty_upper_o,
	output wire        comparator_on_o,
	output wire        pad_measure_on_o,
	output wire [3:0]  pad_measure_sel_o,
	output wire [7:0]  pad_measure_pa_o,
	output wire [7:0]  pad_measure_pb_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	reg        vref_ext_r;
	reg  [1:0] vref_lvl_r;
	reg  [7:0] samp_res_r;
	reg  [7:0] wake_r;
	reg  [7:0] apin_r;
	reg  [5:0] trim_r;
	reg  [7:0] edge_r;
	reg  [1:0] t1_hi_r;
	reg  [3:0] pwm12_r;
	reg  [1:0] t4_hi_r;
	reg  [3:0] pwm34_r;
	reg        cmp_on_r;
	reg        pad_on_r;
	reg  [3:0] pad_sel_r;
	reg  [7:0] rdata_nxt;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	// Full-byte compare so neighbours outside the bank never alias in
	wire wr_vref   = wr_i & (addr_i == `SACF_OFS_VREF);
	wire wr_samp   = wr_i & (addr_i == `SACF_OFS_SAMPRES);
	wire wr_wake   = wr_i & (addr_i == `SACF_OFS_WAKE);
	wire wr_apin   = wr_i & (addr_i == `SACF_OFS_APIN);
	wire wr_trim   = wr_i & (addr_i == `SACF_OFS_TRIM);
	wire wr_edge   = wr_i & (addr_i == `SACF_OFS_EDGE);
	wire wr_t1h    = wr_i & (addr_i == `SACF_OFS_T1H);
	wire wr_ana    = wr_i & (addr_i == `SACF_OFS_ANALOG_CIRCUIT_ENABLE);
	wire wr_pad    = wr_i & (addr_i == `SACF_OFS_PADSEL);
	wire wr_t4h    = wr_i & (addr_i == `SACF_OFS_T4H);

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// One process per register, so each field's reset and write sit together.
	// Unused bit positions are simply not stored: writes to them are lost.
	// Load pulses tell the timers to take the new upper reload bits
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tmr1_load_o <= 1'b0;
			tmr4_load_o <= 1'b0;
		end else begin
			tmr1_load_o <= wr_t1h;
			tmr4_load_o <= wr_t4h;
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			vref_ext_r <= `SACF_RST_VREF_EXT;
			vref_lvl_r <= `SACF_RST_VREF_LVL;
		end else if (wr_vref) begin
			vref_ext_r <= wdata_i[`SACF_VREF_EXT_BIT];
			vref_lvl_r <= wdata_i[1:0];
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			samp_res_r <= `SACF_RST_SAMPRES;
		else if (wr_samp)
			samp_res_r <= wdata_i;
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			wake_r <= `SACF_RST_WAKE;
		else if (wr_wake)
			wake_r <= wdata_i;
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			apin_r <= `SACF_RST_APIN;
		else if (wr_apin)
			apin_r <= wdata_i;
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			trim_r <= `SACF_RST_TRIM;
		else if (wr_trim)
			trim_r <= wdata_i[5:0];
	end

	// Reserved edge code is stored as written; the trigger decode arms nothing
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			edge_r <= `SACF_RST_EDGE;
		else if (wr_edge)
			edge_r <= wdata_i;
	end

	// Reset value of the timer/PWM upper bits is undefined; zero is used
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			t1_hi_r <= `SACF_RST_HIGH2;
			pwm12_r <= `SACF_RST_PWM4;
		end else if (wr_t1h) begin
			t1_hi_r <= wdata_i[5:4];
			pwm12_r <= wdata_i[3:0];
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			t4_hi_r <= `SACF_RST_HIGH2;
			pwm34_r <= `SACF_RST_PWM4;
		end else if (wr_t4h) begin
			t4_hi_r <= wdata_i[7:6];
			pwm34_r <= wdata_i[3:0];
		end
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			cmp_on_r <= `SACF_RST_CMP;
		else if (wr_ana)
			cmp_on_r <= wdata_i[`SACF_CMP_ON_BIT];
	end

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pad_on_r  <= `SACF_RST_PAD_ON;
			pad_sel_r <= `SACF_RST_PAD_SEL;
		end else if (wr_pad) begin
			pad_on_r  <= wdata_i[`SACF_PAD_ON_BIT];
			pad_sel_r <= wdata_i[3:0];
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Timer upper bits read the live count, not what was written.
	always @* begin
		rdata_nxt = 8'h00;
		case (addr_i)
			`SACF_OFS_VREF:    rdata_nxt = {vref_ext_r, 5'h00, vref_lvl_r};
			`SACF_OFS_SAMPRES: rdata_nxt = samp_res_r;
			`SACF_OFS_WAKE:    rdata_nxt = wake_r;
			`SACF_OFS_APIN:    rdata_nxt = apin_r;
			`SACF_OFS_TRIM:    rdata_nxt = {2'h0, trim_r};
			`SACF_OFS_EDGE:    rdata_nxt = edge_r;
			`SACF_OFS_T1H:     rdata_nxt = {2'h0, tmr1_count_i[9:8], pwm12_r};
			`SACF_OFS_ANALOG_CIRCUIT_ENABLE:   rdata_nxt = {cmp_on_r, 7'h00};
			`SACF_OFS_PADSEL:  rdata_nxt = {pad_on_r, 3'h0, pad_sel_r};
			`SACF_OFS_T4H:     rdata_nxt = {tmr4_count_i[9:8], 2'h0, pwm34_r};
			default:           rdata_nxt = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Read data register
	// ----------------------------------------
	// Idle data is zero so a stale value never looks like a fresh answer
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_o <= 8'h00;
		else if (rd_i)
			rdata_o <= rdata_nxt;
		else
			rdata_o <= 8'h00;
	end

	// ----------------------------------------
	// Converter controls
	// ----------------------------------------
	assign ext_ref_source_sel_o  = vref_ext_r;
	assign int_ref_level_sel_o   = vref_lvl_r;
	assign ref_use_int_o         = ~vref_ext_r;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_lvl
			// Index 3 VDD, 2 4V, 1 3V, 0 2V; all off while the pad supplies it
			localparam [1:0] LVL = i;
			assign int_ref_onehot_o[i] = ~vref_ext_r & (vref_lvl_r == LVL);
		end
	endgenerate

	assign sample_width_sel_o = samp_res_r[3:2];
	// One-hot count of converter clocks: 1, 2, 4 or 8
	assign sample_clocks_o = 4'h1 << samp_res_r[3:2];

	assign conv_resolution_sel_o = samp_res_r[1:0];
	assign conv_bits_o = samp_res_r[1] ? 4'hc :
	                     (samp_res_r[0] ? 4'ha : 4'h8);

	assign portb_analog_only_o = {samp_res_r[7:4], apin_r[7:5]};
	// Digital input path is gated off for pure analog pins to save power
	assign porta_analog_only_o = apin_r[4:0];

	genvar b;
	generate
		for (b = 1; b < 8; b = b + 1) begin : g_pb_din
			assign portb_din_en_o[b] = ~portb_analog_only_o[b];
		end
		for (b = 0; b < 5; b = b + 1) begin : g_pa_din
			assign porta_din_en_o[b] = ~apin_r[b];
		end
	endgenerate

	assign offset_trim_mag_o  = trim_r[4:0];
	assign offset_trim_sign_o = trim_r[`SACF_TRIM_SIGN_BIT];

	assign porta_pin_wake_en_o = wake_r;

	// ----------------------------------------
	// Interrupt pin and edge selects
	// ----------------------------------------
	assign ext_irq2_pin_sel_o = edge_r[`SACF_EDGE_EXT_IRQ2_PIN_SEL_BIT];
	assign ext_irq1_pin_sel_o = edge_r[`SACF_EDGE_EXT_IRQ1_PIN_SEL_BIT];
	assign ext_irq0_pin_sel_o = edge_r[`SACF_EDGE_EXT_IRQ0_PIN_SEL_BIT];
	assign irq1_edge_sel_o    = edge_r[3:2];
	assign irq0_edge_sel_o    = edge_r[1:0];
	assign irq2_edge_sel_o    = edge_r[`SACF_EDGE_IRQ2_BIT];

	// Trigger as {falling, rising}; the reserved code arms no edge at all
	assign irq0_trig_o = ext_irq0_pin_sel_o ? edge_r[1:0] : 2'h0;
	assign irq1_trig_o = ext_irq1_pin_sel_o ? edge_r[3:2] : 2'h0;
	assign irq2_trig_o = ext_irq2_pin_sel_o ?
	                     (irq2_edge_sel_o ? 2'h1 : 2'h2) : 2'h0;

	// ----------------------------------------
	// Timer and PWM upper bits
	// ----------------------------------------
	assign tmr1_upper_bits_o    = t1_hi_r;
	assign tmr4_upper_bits_o    = t4_hi_r;
	assign pwm_ch1_duty_upper_o = pwm12_r[1:0];
	assign pwm_ch2_duty_upper_o = pwm12_r[3:2];
	assign pwm_ch3_duty_upper_o = pwm34_r[1:0];
	assign pwm_ch4_duty_upper_o = pwm34_r[3:2];

	// ----------------------------------------
	// Comparator and pad measure
	// ----------------------------------------
	assign comparator_on_o   = cmp_on_r;
	assign pad_measure_on_o  = pad_on_r;
	assign pad_measure_sel_o = pad_sel_r;

	sacf_pad_dec u_pad_dec (
		.en_i  (pad_on_r),
		.sel_i (pad_sel_r),
		.pa_o  (pad_measure_pa_o),
		.pb_o  (pad_measure_pb_o)
	);

endmodule

// ---- sacf_map.vh ----
// Register map constants for the converter / interrupt / timer config SFR bank.
// Assumes an 8-bit register port with byte offsets as the core addresses them.
`ifndef SACF_MAP_VH
`define SACF_MAP_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define SACF_OFS_VREF     8'h13
`define SACF_OFS_SAMPRES  8'h14
`define SACF_OFS_WAKE     8'h15
`define SACF_OFS_APIN     8'h16
`define SACF_OFS_TRIM     8'h17
`define SACF_OFS_EDGE     8'h18
`define SACF_OFS_T1H      8'h19
`define SACF_OFS_ANALOG_CIRCUIT_ENABLE    8'h1a
`define SACF_OFS_PADSEL   8'h1b
`define SACF_OFS_T4H      8'h1c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SACF_VREF_EXT_BIT     7
`define SACF_TRIM_SIGN_BIT    5
`define SACF_EDGE_IRQ2_BIT    7
`define SACF_EDGE_EXT_IRQ2_PIN_SEL_BIT    6
`define SACF_EDGE_EXT_IRQ1_PIN_SEL_BIT    5
`define SACF_EDGE_EXT_IRQ0_PIN_SEL_BIT    4
`define SACF_CMP_ON_BIT       7
`define SACF_PAD_ON_BIT       7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SACF_RST_VREF_EXT   1'b0
`define SACF_RST_VREF_LVL   2'h3
`define SACF_RST_SAMPRES    8'h0a
`define SACF_RST_WAKE       8'h00
`define SACF_RST_APIN       8'h00
`define SACF_RST_TRIM       6'h00
`define SACF_RST_EDGE       8'h05
`define SACF_RST_HIGH2      2'h0
`define SACF_RST_PWM4       4'h0
`define SACF_RST_CMP        1'b0
`define SACF_RST_PAD_ON     1'b0
`define SACF_RST_PAD_SEL    4'h0

// ----------------------------------------
// Encodings
// ----------------------------------------
`define SACF_LVL_VDD   2'h3
`define SACF_LVL_4V    2'h2
`define SACF_LVL_3V    2'h1
`define SACF_LVL_2V    2'h0
`define SACF_RES_8     2'h0
`define SACF_RES_10    2'h1
`define SACF_RES_12    2'h2
`define SACF_EDGE_RSV  2'h0
`define SACF_EDGE_RISE 2'h1
`define SACF_EDGE_FALL 2'h2
`define SACF_EDGE_BOTH 2'h3

`endif

// ---- sacf_pad_dec.v ----
// One-hot pad decoder for the measure function pad select.
// Assumes select and enable come from registers on the same clock.
module sacf_pad_dec (
	input  wire       en_i,
	input  wire [3:0] sel_i,
	output wire [7:0] pa_o,
	output wire [7:0] pb_o
);

	wire [15:0] onehot;

	genvar g;
	generate
		for (g = 0; g < 16; g = g + 1) begin : g_dec
			localparam [3:0] CODE = g;
			assign onehot[g] = en_i & (sel_i == CODE);
		end
	endgenerate

	assign pa_o = onehot[7:0];
	assign pb_o = onehot[15:8];

endmodule

// ---- sacf_regs_checker.sv ----
// Checker for the config register bank: read timing, decodes and timer1 upper bits.
// Assumes one clock, async active-low reset, strobes never both high.
module sacf_regs_checker (
	input logic       mclk_i,
	input logic       nrst_i,
	input logic [7:0] addr_i,
	input logic [7:0] wdata_i,
	input logic       wr_i,
	input logic       rd_i,
	input logic [7:0] rdata_o,
	input logic [9:0] tmr1_count_i,
	input logic       ext_ref_source_sel_o,
	input logic [1:0] int_ref_level_sel_o,
	input logic [3:0] int_ref_onehot_o,
	input logic [1:0] sample_width_sel_o,
	input logic [3:0] sample_clocks_o,
	input logic [1:0] conv_resolution_sel_o,
	input logic [3:0] conv_bits_o,
	input logic       ext_irq2_pin_sel_o,
	input logic       ext_irq0_pin_sel_o,
	input logic [1:0] irq0_edge_sel_o,
	input logic       irq2_edge_sel_o,
	input logic [1:0] irq0_trig_o,
	input logic [1:0] irq2_trig_o,
	input logic [1:0] tmr1_upper_bits_o,
	input logic       tmr1_load_o,
	input logic [1:0] pwm_ch1_duty_upper_o,
	input logic [1:0] pwm_ch2_duty_upper_o,
	input logic       pad_measure_on_o,
	input logic [3:0] pad_measure_sel_o,
	input logic [7:0] pad_measure_pa_o,
	input logic [7:0] pad_measure_pb_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);

	a_idle_read_zero: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
	a_vref_read_back: assert property (rd_i && addr_i == 8'h13 |=>
		rdata_o == {ext_ref_source_sel_o, 5'h00, int_ref_level_sel_o}) else $error("vref read");
	a_ref_onehot: assert property (int_ref_onehot_o ==
		(ext_ref_source_sel_o ? 4'h0 : 4'h1 << int_ref_level_sel_o)) else $error("ref decode");
	a_sample_clocks: assert property (sample_clocks_o == 4'h1 << sample_width_sel_o)
		else $error("sample width");
	a_conv_bits: assert property (conv_bits_o == (conv_resolution_sel_o[1] ? 4'hc :
		(conv_resolution_sel_o[0] ? 4'ha : 4'h8))) else $error("resolution");
	a_tmr1_reload: assert property (wr_i && addr_i == 8'h19 |=> tmr1_load_o &&
		tmr1_upper_bits_o == $past(wdata_i[5:4])) else $error("timer1 reload");
	a_tmr1_live_read: assert property (rd_i && addr_i == 8'h19 |=> rdata_o ==
		{2'h0, $past(tmr1_count_i[9:8]), pwm_ch2_duty_upper_o, pwm_ch1_duty_upper_o})
		else $error("timer1 read");
	a_irq0_trig: assert property (irq0_trig_o ==
		(ext_irq0_pin_sel_o ? irq0_edge_sel_o : 2'h0)) else $error("irq0 edge");
	a_irq2_trig: assert property (irq2_trig_o == (ext_irq2_pin_sel_o ?
		(irq2_edge_sel_o ? 2'h1 : 2'h2) : 2'h0)) else $error("irq2 edge");
	a_pad_onehot: assert property ({pad_measure_pb_o, pad_measure_pa_o} ==
		(pad_measure_on_o ? 16'h1 << pad_measure_sel_o : 16'h0)) else $error("pad decode");
endmodule

// ---- sacf_tb.sv ----
// Self-checking bench for the config register bank, driven over the register port.
// Assumes the bank answers reads one cycle after the strobe and never stalls.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       mclk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
	logic [9:0] tmr1_count_i = 10'h000, tmr4_count_i = 10'h000;
	wire  [7:0] rdata_o, pa_o, pb_o;
	wire  [3:0] conv_bits_o;
	wire  [1:0] t1_up, t4_up, trig0;
	int         mismatches = 0, checked = 0;
	logic [7:0] rst_val [10] = '{8'h03, 8'h0a, 0, 0, 0, 8'h05, 0, 0, 0, 0};
	logic [7:0] ful_val [10] = '{8'h83, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h2f, 8'h80,
		8'h8f, 8'h4f};

	sacf_regs i_dut (.mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.tmr1_count_i, .tmr4_count_i, .ext_ref_source_sel_o(), .int_ref_level_sel_o(),
		.ref_use_int_o(), .int_ref_onehot_o(), .sample_width_sel_o(), .sample_clocks_o(),
		.conv_resolution_sel_o(), .conv_bits_o, .portb_analog_only_o(), .portb_din_en_o(),
		.porta_analog_only_o(), .porta_din_en_o(), .offset_trim_mag_o(),
		.offset_trim_sign_o(), .porta_pin_wake_en_o(), .ext_irq2_pin_sel_o(),
		.ext_irq1_pin_sel_o(), .ext_irq0_pin_sel_o(), .irq1_edge_sel_o(), .irq0_edge_sel_o(),
		.irq2_edge_sel_o(), .irq0_trig_o(trig0), .irq1_trig_o(), .irq2_trig_o(),
		.tmr1_upper_bits_o(t1_up), .tmr1_load_o(), .tmr4_upper_bits_o(t4_up),
		.tmr4_load_o(), .pwm_ch1_duty_upper_o(), .pwm_ch2_duty_upper_o(),
		.pwm_ch3_duty_upper_o(), .pwm_ch4_duty_upper_o(), .comparator_on_o(),
		.pad_measure_on_o(), .pad_measure_sel_o(), .pad_measure_pa_o(pa_o),
		.pad_measure_pb_o(pb_o));

	initial forever #20 mclk_i = ~mclk_i;

	// ----------------------------------------
	// Port tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i) begin wr_i <= 1; addr_i <= a; wdata_i <= d; end
		@(posedge mclk_i) wr_i <= 0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i) begin rd_i <= 1; addr_i <= a; end
		@(posedge mclk_i) rd_i <= 0;
		#1 chk(rdata_o, e);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Also checks unmapped neighbours read zero
	task automatic t_reset_values;
		for (int i = 0; i < 10; i++)
			rd(8'h13 + i, rst_val[i]);
		rd(8'h12, 8'h00);
		rd(8'h1d, 8'h00);
		$display("test reset values done");
	endtask
	// Timer reads show live count, not the reload just written
	task automatic t_all_ones;
		tmr1_count_i <= 10'h2aa;
		tmr4_count_i <= 10'h155;
		for (int i = 0; i < 10; i++)
			wr(8'h13 + i, 8'hff);
		wr(8'h1d, 8'hff);
		chk(t1_up, 2'h3);
		chk(t4_up, 2'h3);
		for (int i = 0; i < 10; i++)
			rd(8'h13 + i, ful_val[i]);
		rd(8'h1d, 8'h00);
		$display("test all ones done");
	endtask
	task automatic t_codes;
		for (int i = 0; i < 4; i++) begin
			wr(8'h14, {4'h0, i[1:0], i[1:0]});
			chk(conv_bits_o, i[1] ? 4'hc : (i[0] ? 4'ha : 4'h8));
		end
		// Irq0 edge code 00 is reserved and never written
		for (int i = 1; i < 4; i++) begin
			wr(8'h18, {4'h1, 2'h0, i[1:0]});
			chk(trig0, i[1:0]);
		end
		for (int i = 0; i < 16; i++) begin
			wr(8'h1b, 8'h80 | i[7:0]);
			chk({pb_o, pa_o}, 16'h1 << i);
		end
		wr(8'h1b, 8'h05);
		chk({pb_o, pa_o}, 16'h0);
		$display("test codes done");
	endtask

	initial begin
		repeat (12) @(posedge mclk_i);
		nrst_i <= 1;
		t_reset_values();
		t_all_ones();
		t_codes();
		@(posedge mclk_i) nrst_i <= 0;
		tmr1_count_i <= 10'h000;
		tmr4_count_i <= 10'h000;
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1;
		t_reset_values();
		complete_run();
	end

	initial begin
		repeat (5000) @(posedge mclk_i);
		mismatches++;
		complete_run();
	end
endmodule

bind sacf_regs sacf_regs_checker u_chk (.mclk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .tmr1_count_i, .ext_ref_source_sel_o, .int_ref_level_sel_o, .int_ref_onehot_o,
	.sample_width_sel_o, .sample_clocks_o, .conv_resolution_sel_o, .conv_bits_o,
	.ext_irq2_pin_sel_o, .ext_irq0_pin_sel_o, .irq0_edge_sel_o, .irq2_edge_sel_o,
	.irq0_trig_o, .irq2_trig_o, .tmr1_upper_bits_o, .tmr1_load_o, .pwm_ch1_duty_upper_o,
	.pwm_ch2_duty_upper_o, .pad_measure_on_o, .pad_measure_sel_o, .pad_measure_pa_o,
	.pad_measure_pb_o);
